// *** include/ssr_pkg.sv ***
// Package for the supply supervisor and reset controller.
// Assumes a single 40 MHz clock domain; no register bus.
package ssr_pkg;
    localparam int RAM_SECTIONS = 8;
    localparam int PIN_SEL_W    = 5;
    // Reset cause bit positions
    localparam int CAUSE_PIN    = 0;
    localparam int CAUSE_DOG    = 1;
    localparam int CAUSE_SOFT   = 2;
    localparam int CAUSE_LOCKUP = 3;
    localparam int CAUSE_WAKE   = 4;
    localparam int CAUSE_W      = 5;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h00;
    // Minimum reset pulse on the domain outputs
    localparam int  CLK_PERIOD_NS  = 25;
    localparam int  RST_HOLD_NS    = 100;
    localparam int  RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RST_HOLD_CNT = 4'(RST_HOLD_CYC);

    typedef struct packed {
        logic cpu;
        logic periph;
        logic gpio;
        logic debug;
        logic wire_port;
        logic watchdog;
        logic retained;
        logic cause;
    } ssr_targets_type;

    typedef struct packed {
        logic power;
        logic retention;
    } ssr_ram_cfg_type;

    typedef struct packed {
        logic accessible;
        logic retained;
    } ssr_ram_state_type;
endpackage

// *** testbench/ssr_far_side.sv ***
// Far-side model: core reset request, debug port, watchdog, task triggers.
// Assumes req bits are one-cycle pulses from the bench, all on clk.
`timescale 1ns/1ps
module ssr_far_side
(
    input  wire logic       clk,
    input  wire logic       cpu_rst_n,
    input  wire logic [5:0] req,
    output logic            cpu_reset_request_bit,
    output logic            control_access_port_reset,
    output logic            watchdog_timeout,
    output logic            cpu_lockup,
    output logic            fixed_latency_task,
    output logic            low_power_task
);
    initial
    begin
        {cpu_reset_request_bit, control_access_port_reset, watchdog_timeout} = 3'h0;
        {cpu_lockup, fixed_latency_task, low_power_task} = 3'h0;
    end
    // Request bit and lockup stay up until the core itself is reset
    always @(posedge clk)
    begin
        cpu_reset_request_bit <= req[0] | (cpu_reset_request_bit & cpu_rst_n);
        cpu_lockup            <= req[3] | (cpu_lockup & cpu_rst_n);
        control_access_port_reset <= req[1];
        watchdog_timeout      <= req[2];
        fixed_latency_task    <= req[4];
        low_power_task        <= req[5];
    end
endmodule

// *** testbench/supply_supervisor_reset_ctrl_test.sv ***
// Bench for the supply supervisor: resets, cause, RAM decode, warning.
// Assumes one 40 MHz clock; far side comes from ssr_far_side.
`timescale 1ns/1ps
module supply_supervisor_reset_ctrl_test
    import ssr_pkg::*;
;
    logic clk, resetn, supply_good, regulators_started, below_brownout_threshold;
    logic below_fail_threshold, supply_fail_enable, high_speed_clock_running;
    logic reset_pin_connect, wakeup_detect, debug_mode, system_off_req, cause_clear;
    logic cpu_reset_request_bit, control_access_port_reset, watchdog_timeout, cpu_lockup;
    logic fixed_latency_task, low_power_task, supply_low_warning_event;
    logic nonvolatile_write_block, system_off, fixed_latency_mode, cpu_rst_n, periph_rst_n;
    logic gpio_rst_n, debug_rst_n, debug_wire_port_rst_n, watchdog_rst_n, retained_rst_n;
    logic [31:0]            reset_pins_n;
    logic [PIN_SEL_W-1:0]   reset_pin_select;
    logic [CAUSE_W-1:0]     cause_clear_mask;
    logic [CAUSE_W-1:0]     reset_cause_register;
    logic [5:0]             req;
    ssr_ram_cfg_type   [RAM_SECTIONS-1:0] ram_cfg;
    ssr_ram_state_type [RAM_SECTIONS-1:0] ram_state;
    int fails, tests_run;
    wire [6:0] rv = {cpu_rst_n, periph_rst_n, gpio_rst_n, debug_rst_n,
                     debug_wire_port_rst_n, watchdog_rst_n, retained_rst_n};

    ssr_supervisor i_ssr_supervisor (.clk(clk), .resetn(resetn), .supply_good(supply_good),
        .regulators_started(regulators_started),
        .below_brownout_threshold(below_brownout_threshold),
        .below_fail_threshold(below_fail_threshold),
        .supply_fail_enable(supply_fail_enable),
        .high_speed_clock_running(high_speed_clock_running), .reset_pins_n(reset_pins_n),
        .reset_pin_select(reset_pin_select), .reset_pin_connect(reset_pin_connect),
        .cpu_reset_request_bit(cpu_reset_request_bit),
        .control_access_port_reset(control_access_port_reset),
        .watchdog_timeout(watchdog_timeout), .cpu_lockup(cpu_lockup),
        .wakeup_detect(wakeup_detect), .debug_mode(debug_mode),
        .system_off_req(system_off_req), .fixed_latency_task(fixed_latency_task),
        .low_power_task(low_power_task), .cause_clear(cause_clear),
        .cause_clear_mask(cause_clear_mask), .ram_cfg(ram_cfg), .ram_state(ram_state),
        .supply_low_warning_event(supply_low_warning_event),
        .nonvolatile_write_block(nonvolatile_write_block),
        .reset_cause_register(reset_cause_register), .system_off(system_off),
        .fixed_latency_mode(fixed_latency_mode), .cpu_rst_n(cpu_rst_n),
        .periph_rst_n(periph_rst_n), .gpio_rst_n(gpio_rst_n), .debug_rst_n(debug_rst_n),
        .debug_wire_port_rst_n(debug_wire_port_rst_n), .watchdog_rst_n(watchdog_rst_n),
        .retained_rst_n(retained_rst_n));
    ssr_far_side i_ssr_far_side (.clk(clk), .cpu_rst_n(cpu_rst_n), .req(req),
        .cpu_reset_request_bit(cpu_reset_request_bit),
        .control_access_port_reset(control_access_port_reset),
        .watchdog_timeout(watchdog_timeout), .cpu_lockup(cpu_lockup),
        .fixed_latency_task(fixed_latency_task), .low_power_task(low_power_task));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int i);
        @(posedge clk) req[i] <= 1'b1;
        @(posedge clk) req <= 6'h00;
    endtask
    task automatic clr_cause;
        @(posedge clk) cause_clear <= 1'b1;
        @(posedge clk) cause_clear <= 1'b0;
        tk(1);
    endtask
    // Bounded waits: reset must start promptly and must end again
    task automatic seen_rst(input logic [6:0] ev, input logic [4:0] ec);
        int n;
        #1;
        for (n = 0; n < 12 && cpu_rst_n !== 1'b0; n++) tk(1);
        chk(rv, ev);
        chk(reset_cause_register, ec);
        for (n = 0; n < 40 && rv !== 7'h7F; n++) tk(1);
        chk(rv, 7'h7F);
    endtask
    task automatic quiet(input int c);
        int n;
        n = 0;
        repeat (c) begin tk(1); n += (rv !== 7'h7F); end
        chk(n, 0);
    endtask
    task automatic warns(input int c, input int e);
        int n;
        n = 0;
        repeat (c) begin tk(1); n += (supply_low_warning_event === 1'b1); end
        chk(n, e);
    endtask
    task automatic ram_chk(input logic off);
        logic [1:0] e;
        for (int i = 0; i < RAM_SECTIONS; i++)
        begin
            e = off ? {1'b0, ram_cfg[i].retention}
                    : {ram_cfg[i].power, ram_cfg[i].power | ram_cfg[i].retention};
            chk(ram_state[i], e);
        end
    endtask

    task automatic t_power;
        tk(10);
        chk(rv, 7'h00);
        @(posedge clk) {supply_good, regulators_started} <= 2'h3;
        seen_rst(7'h00, 5'h00);
        chk(fixed_latency_mode, 1'b0);
    endtask
    task automatic t_sources;
        clr_cause;
        pulse(2);
        seen_rst(7'h04, 5'h02);
        for (int i = 0; i < 2; i++)
        begin
            clr_cause;
            pulse(i);
            seen_rst(7'h0F, 5'h04);
        end
        ram_chk(1'b0);
        clr_cause;
        pulse(3);
        seen_rst(7'h0F, 5'h08);
        @(posedge clk) debug_mode <= 1'b1;
        pulse(3);
        quiet(10);
        @(posedge clk) debug_mode <= 1'b0;
    endtask
    task automatic t_pin;
        clr_cause;
        @(posedge clk) reset_pins_n[3] <= 1'b0;
        tk(3);
        @(posedge clk) reset_pins_n[3] <= 1'b1;
        quiet(10);
        // Pin disconnected: a low level on it must not reset
        @(posedge clk) {reset_pin_connect, reset_pins_n[7]} <= 2'h0;
        tk(3);
        @(posedge clk) reset_pins_n[7] <= 1'b1;
        tk(3);
        @(posedge clk) reset_pin_connect <= 1'b1;
        quiet(10);
        @(posedge clk) reset_pins_n[7] <= 1'b0;
        tk(3);
        @(posedge clk) reset_pins_n[7] <= 1'b1;
        seen_rst(7'h04, 5'h01);
    endtask
    task automatic t_off;
        pulse(4);
        tk(2);
        chk(fixed_latency_mode, 1'b1);
        clr_cause;
        @(posedge clk) system_off_req <= 1'b1;
        tk(3);
        chk(system_off, 1'b1);
        ram_chk(1'b1);
        pulse(2);
        quiet(10);
        @(posedge clk) debug_mode <= 1'b1;
        @(posedge clk) {wakeup_detect, system_off_req} <= 2'h2;
        @(posedge clk) wakeup_detect <= 1'b0;
        seen_rst(7'h1D, 5'h10);
        chk(system_off, 1'b0);
        chk(fixed_latency_mode, 1'b0);
        @(posedge clk) debug_mode <= 1'b0;
    endtask
    task automatic t_warn;
        @(posedge clk) below_fail_threshold <= 1'b1;
        warns(8, 0);
        @(posedge clk) supply_fail_enable <= 1'b1;
        warns(10, 1);
        chk(nonvolatile_write_block, 1'b1);
        chk(rv, 7'h7F);
        @(posedge clk) high_speed_clock_running <= 1'b0;
        tk(6);
        chk(nonvolatile_write_block, 1'b0);
        @(posedge clk) {below_fail_threshold, high_speed_clock_running} <= 2'h1;
        tk(6);
        chk(nonvolatile_write_block, 1'b0);
        @(posedge clk) below_fail_threshold <= 1'b1;
        warns(10, 1);
        @(posedge clk) {below_fail_threshold, supply_fail_enable} <= 2'h0;
    endtask
    task automatic t_brown;
        // Wakeup cause from the system off scenario is still standing
        clr_cause;
        pulse(2);
        seen_rst(7'h04, 5'h02);
        @(posedge clk) below_brownout_threshold <= 1'b1;
        tk(8);
        chk(rv, 7'h00);
        chk(reset_cause_register, 5'h00);
        @(posedge clk) below_brownout_threshold <= 1'b0;
        seen_rst(7'h00, 5'h00);
        @(posedge clk) resetn <= 1'b0;
        #1 chk(rv, 7'h00);
        tk(3);
        @(posedge clk) resetn <= 1'b1;
        seen_rst(7'h00, 5'h00);
    endtask

    initial
    begin
        {resetn, supply_good, regulators_started, below_brownout_threshold} = 4'h0;
        {below_fail_threshold, supply_fail_enable, wakeup_detect, debug_mode} = 4'h0;
        {system_off_req, cause_clear} = 2'h0;
        {high_speed_clock_running, reset_pin_connect} = 2'h3;
        reset_pins_n = 32'hFFFFFFFF;
        reset_pin_select = 5'h07;
        cause_clear_mask = 5'h1F;
        req = 6'h00;
        fails = 0;
        tests_run = 0;
        // Power stays on wherever retention is on
        for (int i = 0; i < RAM_SECTIONS; i++)
            ram_cfg[i] = (i % 3 == 0) ? 2'h3 : ((i % 3 == 1) ? 2'h2 : 2'h0);
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_power;
        t_sources;
        t_pin;
        t_off;
        t_warn;
        t_brown;
        stop_test;
    end
    // Whole run is well under 1500 cycles
    initial
    begin
        #(25 * 4000);
        fails++;
        stop_test;
    end
endmodule

// *** verilog/ssr_reset_stretch.sv ***
// One reset domain output: asserted at once, released after a hold count.
// Assumes the request is from logic on clk; rst_n is the synchronised reset.
`timescale 1ns/1ps
module ssr_reset_stretch
    import ssr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic req,
    output logic      dom_rst_n
);
    logic [3:0] hold_reg;

    // Counter restarts while the request stands, so release is clocked
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hold_reg <= RST_HOLD_CNT;
        else if (req)
            hold_reg <= RST_HOLD_CNT;
        else if (hold_reg != 4'h0)
            hold_reg <= hold_reg - 4'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dom_rst_n <= 1'b0;
        else
            dom_rst_n <= !req && (hold_reg == 4'h0);
    end

    chk_release_hold: assert property (@(posedge clk) disable iff (!rst_n)
        req |=> !dom_rst_n [*4])
        else $error("domain reset released too early");
endmodule

// *** verilog/ssr_supervisor.sv ***
// Supply supervisor: reset source collection, domain resets, reset cause,
// RAM section power decode and supply-low warning.
// Assumes analog comparators and reset pins are asynchronous; the rest is on clk.
//
// Overview of operation
// - Warn when enabled supply falls below threshold
// - Warn also if already low at enable
// - Warning notifies only, never resets
// - Block flash writes while warned and low
// - Comparator idle in system off, clock stopped
// - System off: RAM inaccessible, retention setting rules
// - System on: power on means accessible, retained
// - Reset cause readable after every reset
// - Power-on holds all until supply good
// - Selected reset pin triggers pin reset
// - Wakeup resets CPU, peripherals, debug, watchdog only
// - Debug mode wakeup spares debug components
// - Soft reset: CPU, peripherals, GPIO only
// - Watchdog resets system, never in system off
// - Pin/watchdog reset all except wire port, cause
// - Brownout clears every target including cause
// - Lockup resets CPU set, not in debug
// - RAM is never cleared by reset
// - Retained registers survive non-targeting resets
`timescale 1ns/1ps
module ssr_supervisor
    import ssr_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    supply_good,
    input  wire logic                    regulators_started,
    input  wire logic                    below_brownout_threshold,
    input  wire logic                    below_fail_threshold,
    input  wire logic                    supply_fail_enable,
    input  wire logic                    high_speed_clock_running,
    input  wire logic [31:0]             reset_pins_n,
    input  wire logic [PIN_SEL_W-1:0]    reset_pin_select,
    input  wire logic                    reset_pin_connect,
    input  wire logic                    cpu_reset_request_bit,
    input  wire logic                    control_access_port_reset,
    input  wire logic                    watchdog_timeout,
    input  wire logic                    cpu_lockup,
    input  wire logic                    wakeup_detect,
    input  wire logic                    debug_mode,
    input  wire logic                    system_off_req,
    input  wire logic                    fixed_latency_task,
    input  wire logic                    low_power_task,
    input  wire logic                    cause_clear,
    input  wire logic [CAUSE_W-1:0]      cause_clear_mask,
    input  ssr_ram_cfg_type [RAM_SECTIONS-1:0] ram_cfg,
    output ssr_ram_state_type [RAM_SECTIONS-1:0] ram_state,
    output logic                         supply_low_warning_event,
    output logic                         nonvolatile_write_block,
    output logic [CAUSE_W-1:0]           reset_cause_register,
    output logic                         system_off,
    output logic                         fixed_latency_mode,
    output logic                         cpu_rst_n,
    output logic                         periph_rst_n,
    output logic                         gpio_rst_n,
    output logic                         debug_rst_n,
    output logic                         debug_wire_port_rst_n,
    output logic                         watchdog_rst_n,
    output logic                         retained_rst_n
);
    logic rst_s1_reg;
    logic rst_n_int;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [31:0] pin1_reg;
    logic [31:0] pin2_reg;
    logic fail_low_prev_reg;
    logic pwr_ok_reg;
    logic dog_prev_reg;
    logic lock_prev_reg;
    logic sreq_prev_reg;
    logic cap_prev_reg;
    logic wake_prev_reg;
    logic pin_prev_reg;
    logic pin_low;
    logic src_pin;
    logic src_dog;
    logic src_soft;
    logic src_lock;
    logic src_wake;
    logic fail_active;
    ssr_targets_type tgt;
    ssr_targets_type tgt_pwr;
    logic [CAUSE_W-1:0] cause_set;

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_reg <= 1'b0;
            rst_n_int  <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n_int  <= rst_s1_reg;
        end
    end

    // Analog levels and pins cross into clk through two stages
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            pin1_reg  <= 32'hFFFFFFFF;
            pin2_reg  <= 32'hFFFFFFFF;
        end
        else
        begin
            sync1_reg <= {supply_good && regulators_started, below_brownout_threshold,
                          below_fail_threshold};
            sync2_reg <= sync1_reg;
            pin1_reg  <= reset_pins_n;
            pin2_reg  <= pin1_reg;
        end
    end

    function automatic logic rise(input logic now, input logic prev);
        return now && !prev;
    endfunction

    // Power-on and brownout gate every domain
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
            pwr_ok_reg <= 1'b0;
        else
            pwr_ok_reg <= sync2_reg[2] && !sync2_reg[1];
    end

    assign pin_low  = reset_pin_connect && !pin2_reg[reset_pin_select];
    assign src_pin  = rise(pin_low, pin_prev_reg);
    assign src_dog  = rise(watchdog_timeout, dog_prev_reg) && !system_off;
    assign src_soft = rise(cpu_reset_request_bit, sreq_prev_reg)
                   || rise(control_access_port_reset, cap_prev_reg);
    assign src_lock = rise(cpu_lockup, lock_prev_reg) && !debug_mode
                   && !system_off;
    assign src_wake = system_off && rise(wakeup_detect, wake_prev_reg);

    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            pin_prev_reg  <= 1'b0;
            dog_prev_reg  <= 1'b0;
            sreq_prev_reg <= 1'b0;
            cap_prev_reg  <= 1'b0;
            lock_prev_reg <= 1'b0;
            wake_prev_reg <= 1'b0;
        end
        else
        begin
            pin_prev_reg  <= pin_low;
            dog_prev_reg  <= watchdog_timeout;
            sreq_prev_reg <= cpu_reset_request_bit;
            cap_prev_reg  <= control_access_port_reset;
            lock_prev_reg <= cpu_lockup;
            wake_prev_reg <= wakeup_detect;
        end
    end

    // Per-target request; the warning never appears here
    always_comb
    begin
        tgt_pwr = '{default: !pwr_ok_reg};
        tgt.cpu       = tgt_pwr.cpu || src_pin || src_dog || src_soft || src_lock
                     || src_wake;
        tgt.periph    = tgt.cpu;
        tgt.gpio      = tgt_pwr.gpio || src_pin || src_dog || src_soft || src_lock;
        tgt.debug     = tgt_pwr.debug || src_pin || src_dog
                     || (src_wake && !debug_mode);
        tgt.wire_port = tgt_pwr.wire_port;
        tgt.watchdog  = tgt_pwr.watchdog || src_pin || src_dog || src_wake;
        tgt.retained  = tgt_pwr.retained || src_pin || src_dog;
        tgt.cause     = tgt_pwr.cause;
    end

    ssr_reset_stretch u_cpu (.clk(clk), .rst_n(rst_n_int), .req(tgt.cpu),
        .dom_rst_n(cpu_rst_n));
    ssr_reset_stretch u_per (.clk(clk), .rst_n(rst_n_int), .req(tgt.periph),
        .dom_rst_n(periph_rst_n));
    ssr_reset_stretch u_gpio (.clk(clk), .rst_n(rst_n_int), .req(tgt.gpio),
        .dom_rst_n(gpio_rst_n));
    ssr_reset_stretch u_dbg (.clk(clk), .rst_n(rst_n_int), .req(tgt.debug),
        .dom_rst_n(debug_rst_n));
    ssr_reset_stretch u_wire (.clk(clk), .rst_n(rst_n_int), .req(tgt.wire_port),
        .dom_rst_n(debug_wire_port_rst_n));
    ssr_reset_stretch u_dog (.clk(clk), .rst_n(rst_n_int), .req(tgt.watchdog),
        .dom_rst_n(watchdog_rst_n));
    ssr_reset_stretch u_ret (.clk(clk), .rst_n(rst_n_int), .req(tgt.retained),
        .dom_rst_n(retained_rst_n));

    // Reset cause: sticky, set wins over software clear
    always_comb
    begin
        cause_set = CAUSE_RESET;
        cause_set[CAUSE_PIN]    = src_pin;
        cause_set[CAUSE_DOG]    = src_dog;
        cause_set[CAUSE_SOFT]   = src_soft;
        cause_set[CAUSE_LOCKUP] = src_lock;
        cause_set[CAUSE_WAKE]   = src_wake;
    end

    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
            reset_cause_register <= CAUSE_RESET;
        else if (tgt.cause)
            reset_cause_register <= CAUSE_RESET;
        else
            reset_cause_register <= (reset_cause_register
                & ~(cause_clear ? cause_clear_mask : CAUSE_RESET)) | cause_set;
    end

    // System off state; wakeup, pin reset, power-on or brownout return to system on
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
            system_off <= 1'b0;
        else if (!pwr_ok_reg || src_wake || src_pin)
            system_off <= 1'b0;
        else if (system_off_req)
            system_off <= 1'b1;
    end

    // Sub-mode: low power after entering system on
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
            fixed_latency_mode <= 1'b0;
        else if (system_off || !pwr_ok_reg)
            fixed_latency_mode <= 1'b0;
        else if (low_power_task)
            fixed_latency_mode <= 1'b0;
        else if (fixed_latency_task)
            fixed_latency_mode <= 1'b1;
    end

    // Comparator runs only in system on with the fast clock present
    assign fail_active = supply_fail_enable && !system_off
                      && high_speed_clock_running;

    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
            fail_low_prev_reg <= 1'b0;
        else
            fail_low_prev_reg <= fail_active && sync2_reg[0];
    end

    // Edge on the gated low condition covers falling supply, late enable
    // and threshold raised above supply alike
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
            supply_low_warning_event <= 1'b0;
        else
            supply_low_warning_event <= fail_active && sync2_reg[0]
                                     && !fail_low_prev_reg;
    end

    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
            nonvolatile_write_block <= 1'b0;
        else
            nonvolatile_write_block <= fail_active && sync2_reg[0];
    end

    // RAM decode only; contents are never cleared here
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
            ram_state <= '0;
        else
            for (int i = 0; i < RAM_SECTIONS; i++)
            begin
                ram_state[i].accessible <= !system_off && ram_cfg[i].power;
                ram_state[i].retained   <= ram_cfg[i].retention
                    || (!system_off && ram_cfg[i].power);
            end
    end

    chk_warn_no_reset: assert property (@(posedge clk) disable iff (!rst_n_int)
        supply_low_warning_event && pwr_ok_reg && !src_pin && !src_dog && !src_soft
        && !src_lock && !src_wake |=> cpu_rst_n || !$past(cpu_rst_n))
        else $error("warning caused a reset");
    chk_block_off: assert property (@(posedge clk) disable iff (!rst_n_int)
        $past(system_off) |-> !nonvolatile_write_block && !supply_low_warning_event)
        else $error("comparator active in system off");
    chk_block_on: assert property (@(posedge clk) disable iff (!rst_n_int)
        fail_active && sync2_reg[0] |=> nonvolatile_write_block)
        else $error("write not blocked");
    chk_dog_off: assert property (@(posedge clk) disable iff (!rst_n_int)
        system_off && watchdog_timeout && !dog_prev_reg |=> !reset_cause_register[CAUSE_DOG]
        || $past(reset_cause_register[CAUSE_DOG]))
        else $error("watchdog reset in system off");
    chk_soft_keeps: assert property (@(posedge clk) disable iff (!rst_n_int)
        src_soft && pwr_ok_reg && !src_pin && !src_dog && !src_wake |-> !tgt.watchdog
        && !tgt.retained && !tgt.debug)
        else $error("soft reset reached foreign domain");
    chk_lock_debug: assert property (@(posedge clk) disable iff (!rst_n_int)
        debug_mode |-> !src_lock)
        else $error("lockup reset in debug mode");
    chk_wake_debug: assert property (@(posedge clk) disable iff (!rst_n_int)
        src_wake && debug_mode && pwr_ok_reg && !src_pin && !src_dog |-> !tgt.debug)
        else $error("debug reset on debug-mode wakeup");
    chk_cause_keep: assert property (@(posedge clk) disable iff (!rst_n_int)
        src_pin && pwr_ok_reg |=> reset_cause_register[CAUSE_PIN])
        else $error("pin cause lost");
    chk_ram_off: assert property (@(posedge clk) disable iff (!rst_n_int)
        system_off && ram_cfg[0].retention |=> ram_state[0].retained)
        else $error("retention lost in system off");
endmodule
